// [include/trim_loader_pkg.sv]
// Constants, field layout and register map of the single-wire trim loader.
// Assumes a 25 MHz system clock and decoded supply-mode indications.
package trim_loader_pkg;

  // Clock rate and timing figures.
  localparam int CLK_MHZ       = 25;
  localparam int BIT_SAMPLE_NS = 2000;
  localparam int BIT_SAMPLE_CYC = (BIT_SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int BURN_TIME_US  = 100;
  localparam int BURN_CYC      = BURN_TIME_US * CLK_MHZ;
  localparam logic [5:0]  SAMPLE_CNT = 6'(BIT_SAMPLE_CYC);
  localparam logic [11:0] BURN_CNT   = 12'(BURN_CYC);

  // Settings word and the 31-bit image that the fuses mirror.
  localparam int WORD_BITS   = 37;
  localparam int IMAGE_BITS  = 31;
  localparam logic [5:0] LAST_BIT = 6'(WORD_BITS - 1);
  localparam logic [IMAGE_BITS-1:0] IMAGE_RESET = 31'h0;

  // Field positions inside the image.
  localparam int OFFSET_LSB  = 0;
  localparam int OFFSET_W    = 10;
  localparam int HALF_POS    = 10;
  localparam int COARSE_LSB  = 11;
  localparam int COARSE_W    = 3;
  localparam int FINE_LSB    = 14;
  localparam int FINE_W      = 10;
  localparam int SLOPE_POS   = 24;
  localparam int THERMAL_LSB = 25;
  localparam int THERMAL_W   = 5;
  localparam int LOCK_POS    = 30;

  // Register byte offsets.
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_SETTINGS = 4'h8;
  localparam logic [3:0] REG_FUSE     = 4'hc;

  // Control and status bit positions and reset values.
  localparam int CTRL_LOAD_EN_POS   = 0;
  localparam int CTRL_COMMIT_EN_POS = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int STAT_NORMAL_POS = 0;
  localparam int STAT_LOAD_POS   = 1;
  localparam int STAT_COMMIT_POS = 2;
  localparam int STAT_LOADED_POS = 3;
  localparam int STAT_BURN_POS   = 4;
  localparam int STAT_LOCKED_POS = 5;
  localparam int STAT_COUNT_LSB  = 8;

  typedef enum logic [1:0] {st_init, st_idle, st_burn} ctl_state_t;

endpackage

// [hdl/bit_recover.sv]
// Recovers bits from the self-clocked programming line.
// Assumes the line input is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module bit_recover (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic enable_i,
  input  wire logic line_i,
  output logic      bit_strobe_o,
  output logic      bit_value_o
);
  import trim_loader_pkg::*;

  logic       line_prev;
  logic       busy;
  logic [5:0] cnt;
  logic       next_line_prev;
  logic       next_busy;
  logic [5:0] next_cnt;
  logic       next_strobe;
  logic       next_value;

  // A rising edge opens a bit; its value is the level a fixed time later.
  always_comb begin
    next_line_prev = line_i;
    next_busy      = busy;
    next_cnt       = cnt;
    next_strobe    = 1'b0;
    next_value     = bit_value_o;
    if (!enable_i) begin
      next_busy = 1'b0;
      next_cnt  = 6'h0;
    end else if (busy) begin
      next_cnt = cnt + 6'h1;
      if (cnt == SAMPLE_CNT) begin
        next_strobe = 1'b1;
        next_value  = line_i;
        next_busy   = 1'b0;
        next_cnt    = 6'h0;
      end
    end else if (line_i && !line_prev) begin
      next_busy = 1'b1;
      next_cnt  = 6'h1;
    end
  end

  // State registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      line_prev    <= 1'b1;
      busy         <= 1'b0;
      cnt          <= 6'h0;
      bit_strobe_o <= 1'b0;
      bit_value_o  <= 1'b0;
    end else begin
      line_prev    <= next_line_prev;
      busy         <= next_busy;
      cnt          <= next_cnt;
      bit_strobe_o <= next_strobe;
      bit_value_o  <= next_value;
    end
  end

endmodule
`default_nettype wire

// [hdl/single_wire_trim_loader.sv]
// Programming path of a programmable linear Hall sensor: load and commit.
// Assumes decoded supply-mode inputs and an external fuse array that
// reports its state on fuse_state_i and burns while fuse_burn_o is high.
//
// How it works
// - In normal supply band the pin stays an output and programming is ignored.
// - At load level the pin becomes an input taking 37-bit words.
// - Each bit starts on a rising line edge, counted from load entry.
// - Each word overwrites the temporary register, any number of times.
// - The temporary register drives the transfer settings at once.
// - At commit level the fuses take the temporary register's 30 setting bits plus a set lock bit.
// - Commit happens once only; burned fuses lock the device for good.
// - A ten-bit quiescent offset code gives 1024 steps.
// - One half-supply range bit picks wide or narrow offset range.
// - A three-bit coarse gain code picks one of eight steps.
// - A ten-bit fine gain code gives 1024 steps per coarse step.
// - A slope reverse bit inverts the field response polarity.
// - A five-bit thermal compensation code picks one of 32 steps.
// - An unprogrammed device uses thermal compensation code zero.
`timescale 1ns/1ps
`default_nettype none
module single_wire_trim_loader (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        mode_normal_i,
  input  wire logic        mode_load_i,
  input  wire logic        mode_commit_i,
  input  wire logic        pin_line_i,
  output logic             pin_oe_o,
  input  wire logic [trim_loader_pkg::IMAGE_BITS-1:0] fuse_state_i,
  output logic             fuse_burn_o,
  output logic [trim_loader_pkg::IMAGE_BITS-1:0] fuse_word_o,
  output logic [9:0]       quiescent_offset_code_o,
  output logic             half_supply_range_o,
  output logic [2:0]       coarse_gain_code_o,
  output logic [9:0]       fine_gain_code_o,
  output logic             slope_reverse_o,
  output logic [4:0]       thermal_comp_code_o
);
  import trim_loader_pkg::*;

  ctl_state_t            state;
  ctl_state_t            next_state;
  logic [IMAGE_BITS-1:0] image;
  logic [IMAGE_BITS-1:0] next_image;
  logic [WORD_BITS-1:0]  shift;
  logic [WORD_BITS-1:0]  next_shift;
  logic [5:0]            bit_count;
  logic [5:0]            next_bit_count;
  logic [11:0]           burn_cnt;
  logic [11:0]           next_burn_cnt;
  logic [IMAGE_BITS-1:0] next_fuse_word;
  logic                  locked;
  logic                  next_locked;
  logic                  word_loaded;
  logic                  next_word_loaded;
  logic                  commit_prev;
  logic                  word_done;
  logic [1:0]            ctrl;
  logic [1:0]            next_ctrl;
  logic                  ack;
  logic                  next_ack;
  logic [31:0]           next_readdata;
  logic                  load_active;
  logic                  rx_enable;
  logic                  bit_strobe;
  logic                  bit_value;
  logic                  bus_wr;
  logic                  status_clear;

  // Load mode counts only when the supply is not at commit level.
  assign load_active = mode_load_i && !mode_commit_i
                       && ctrl[CTRL_LOAD_EN_POS];
  assign rx_enable   = load_active && (state == st_idle);
  // The pin drives the analog output only inside the normal band.
  assign pin_oe_o    = mode_normal_i && !mode_load_i
                       && !mode_commit_i;
  assign fuse_burn_o = (state == st_burn);

  bit_recover u_bit_recover (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .enable_i     (rx_enable),
    .line_i       (pin_line_i),
    .bit_strobe_o (bit_strobe),
    .bit_value_o  (bit_value)
  );

  // Settings outputs come straight from the temporary register.
  assign quiescent_offset_code_o =
    image[OFFSET_LSB +: OFFSET_W];
  assign half_supply_range_o = image[HALF_POS];
  assign coarse_gain_code_o  = image[COARSE_LSB +: COARSE_W];
  assign fine_gain_code_o    = image[FINE_LSB +: FINE_W];
  assign slope_reverse_o     = image[SLOPE_POS];
  assign thermal_comp_code_o = image[THERMAL_LSB +: THERMAL_W];

  // Bus write strobes for the status word-loaded flag.
  assign bus_wr = avs_write_i && ack;
  assign status_clear = bus_wr && (avs_address_i == REG_STATUS)
                        && avs_byteenable_i[0]
                        && avs_writedata_i[STAT_LOADED_POS];

  // Control sequencing: power-up image, word shifting and fuse commit.
  always_comb begin
    next_state       = state;
    next_image       = image;
    next_shift       = shift;
    next_bit_count   = bit_count;
    next_burn_cnt    = burn_cnt;
    next_fuse_word   = fuse_word_o;
    next_locked      = locked;
    next_word_loaded = word_loaded;
    word_done        = 1'b0;
    unique case (state)
      st_init: begin
        next_locked = fuse_state_i[LOCK_POS];
        next_image  = fuse_state_i[LOCK_POS] ? fuse_state_i
                                             : IMAGE_RESET;
        next_state  = st_idle;
      end
      st_idle: begin
        if (!load_active) begin
          next_bit_count = 6'h0;
        end else if (bit_strobe) begin
          next_shift = {shift[WORD_BITS-2:0], bit_value};
          next_bit_count = bit_count + 6'h1;
          if (bit_count == LAST_BIT) begin
            word_done      = 1'b1;
            next_bit_count = 6'h0;
            next_image     = {image[LOCK_POS],
                              next_shift[LOCK_POS-1:0]};
          end
        end
        if (mode_commit_i && !commit_prev && !locked
            && ctrl[CTRL_COMMIT_EN_POS]) begin
          next_state     = st_burn;
          next_burn_cnt  = 12'h0;
          next_bit_count = 6'h0;
          next_fuse_word = {1'b1, image[LOCK_POS-1:0]};
        end
      end
      st_burn: begin
        next_burn_cnt = burn_cnt + 12'h1;
        if (burn_cnt == BURN_CNT - 12'h1) begin
          next_state        = st_idle;
          next_locked       = 1'b1;
          next_image[LOCK_POS] = 1'b1;
        end
      end
      default: next_state = st_init;
    endcase
    // A new word wins over a software clear in the same cycle.
    if (status_clear) begin
      next_word_loaded = 1'b0;
    end
    if (word_done) begin
      next_word_loaded = 1'b1;
    end
  end

  // Control registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state       <= st_init;
      image       <= IMAGE_RESET;
      shift       <= '0;
      bit_count   <= 6'h0;
      burn_cnt    <= 12'h0;
      fuse_word_o <= IMAGE_RESET;
      locked      <= 1'b0;
      word_loaded <= 1'b0;
      commit_prev <= 1'b0;
    end else begin
      state       <= next_state;
      image       <= next_image;
      shift       <= next_shift;
      bit_count   <= next_bit_count;
      burn_cnt    <= next_burn_cnt;
      fuse_word_o <= next_fuse_word;
      locked      <= next_locked;
      word_loaded <= next_word_loaded;
      commit_prev <= mode_commit_i;
    end
  end

  // Bus slave: one wait cycle, then the answer stands for one edge.
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;

  always_comb begin
    next_ack      = (avs_read_i || avs_write_i) && !ack;
    next_ctrl     = ctrl;
    next_readdata = avs_readdata_o;
    if (bus_wr && avs_address_i == REG_CTRL && avs_byteenable_i[0]) begin
      next_ctrl = avs_writedata_i[1:0];
    end
    if (avs_read_i && !ack) begin
      next_readdata = 32'h0;
      unique case (avs_address_i)
        REG_CTRL: next_readdata[1:0] = ctrl;
        REG_STATUS: begin
          next_readdata[STAT_NORMAL_POS] = mode_normal_i;
          next_readdata[STAT_LOAD_POS]   = mode_load_i;
          next_readdata[STAT_COMMIT_POS] = mode_commit_i;
          next_readdata[STAT_LOADED_POS] = word_loaded;
          next_readdata[STAT_BURN_POS]   = fuse_burn_o;
          next_readdata[STAT_LOCKED_POS] = locked;
          next_readdata[STAT_COUNT_LSB +: 6] = bit_count;
        end
        REG_SETTINGS: next_readdata[IMAGE_BITS-1:0] = image;
        REG_FUSE: next_readdata[IMAGE_BITS-1:0] = fuse_state_i;
        default: next_readdata = 32'h0;
      endcase
    end
  end

  // Bus registers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack            <= 1'b0;
      ctrl           <= CTRL_RESET;
      avs_readdata_o <= 32'h0;
    end else begin
      ack            <= next_ack;
      ctrl           <= next_ctrl;
      avs_readdata_o <= next_readdata;
    end
  end

  // Checks of the documented behaviour.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_normal_ignores;
    (mode_normal_i && !mode_load_i && !mode_commit_i)
      |-> pin_oe_o && !rx_enable ##1 !word_done;
  endproperty
  a_normal_ignores: assert property (p_normal_ignores)
    else $error("Programming accepted in normal band.");

  property p_load_input;
    mode_load_i |-> !pin_oe_o;
  endproperty
  a_load_input: assert property (p_load_input)
    else $error("Pin driven while in load mode.");

  property p_bit_counts;
    (bit_strobe && rx_enable) |=> (bit_count == $past(bit_count) + 6'h1)
      || (bit_count == 6'h0 && $past(bit_count) == LAST_BIT);
  endproperty
  a_bit_counts: assert property (p_bit_counts)
    else $error("Bit strobe did not advance the bit count.");

  property p_word_replaces;
    word_done |=> image[LOCK_POS-1:0] == $past(next_shift[LOCK_POS-1:0]);
  endproperty
  a_word_replaces: assert property (p_word_replaces)
    else $error("Loaded word did not replace the register.");

  property p_settings_applied;
    word_done |=> ##1 quiescent_offset_code_o
      == $past(next_shift[OFFSET_LSB +: OFFSET_W], 2)
      && thermal_comp_code_o == $past(next_shift[THERMAL_LSB +: 5], 2);
  endproperty
  a_settings_applied: assert property (p_settings_applied)
    else $error("Settings outputs do not follow the loaded word.");

  property p_commit_burns;
    (state == st_idle && mode_commit_i && !commit_prev && !locked
     && ctrl[CTRL_COMMIT_EN_POS])
      |=> fuse_burn_o [*8] ##0 fuse_word_o == {1'b1, $past(image[29:0], 8)};
  endproperty
  a_commit_burns: assert property (p_commit_burns)
    else $error("Commit did not burn the register image.");

  property p_once_only;
    (locked && !fuse_burn_o) |=> !fuse_burn_o && locked;
  endproperty
  a_once_only: assert property (p_once_only)
    else $error("Fuses burned again after lock.");

  property p_power_up;
    (state == st_init) |=> image == ($past(fuse_state_i[LOCK_POS])
      ? $past(fuse_state_i) : IMAGE_RESET);
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("Power-up image not taken from fuses or zeros.");

  property p_thermal_default;
    (state == st_init && !fuse_state_i[LOCK_POS])
      |=> thermal_comp_code_o == 5'h0;
  endproperty
  a_thermal_default: assert property (p_thermal_default)
    else $error("Unprogrammed thermal code is not zero.");

  property p_bus_answer;
    (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus request not answered within one cycle.");

  c_word_loaded: cover property (word_done);
  c_two_words: cover property (word_done && word_loaded);
  c_commit_done: cover property ($fell(fuse_burn_o));
  c_status_clear: cover property (status_clear && word_done);

endmodule
`default_nettype wire

// [dv/trim_programmer.sv]
// Programmer model: drives the supply modes and the shared programming line.
// Assumes its tasks are called from a process clocked by clk_i.
`timescale 1ns/1ps
`default_nettype none
module trim_programmer (
  input  wire logic clk_i,
  output var logic  mode_normal_o,
  output var logic  mode_load_o,
  output var logic  mode_commit_o,
  output var logic  line_o
);
  logic busy;
  logic tx_level;

  // Starts in the normal band with the line quiet.
  initial begin
    {mode_normal_o, mode_load_o, mode_commit_o} = 3'b100;
    line_o = 1'b0;
    busy = 1'b0;
    tx_level = 1'b0;
  end

  // Unless sending, the pin carries a moving analog level in the normal band, else low.
  always @(posedge clk_i) begin
    line_o <= busy ? tx_level : (mode_normal_o & ~line_o);
  end

  // Passes through a dead band so no stray edge lands on mode entry.
  task automatic set_mode(input logic [2:0] m);
    @(posedge clk_i);
    {mode_normal_o, mode_load_o, mode_commit_o} <= 3'b000;
    repeat (3) @(posedge clk_i);
    {mode_normal_o, mode_load_o, mode_commit_o} <= m;
    repeat (3) @(posedge clk_i);
  endtask

  // Sends the top n bits MSB first: rise, 5 high, value 50, low 5 cycles.
  task automatic send(input logic [36:0] w, input int n);
    for (int i = 36; i > 36 - n; i--) begin
      @(posedge clk_i);
      busy <= 1'b1;
      tx_level <= 1'b1;
      repeat (5) @(posedge clk_i);
      tx_level <= w[i];
      repeat (50) @(posedge clk_i);
      tx_level <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
    busy <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/tb_single_wire_trim_loader.sv]
// Self-checking bench for the trim loader: bus, programming line, commit.
// Assumes the loader package and the programmer model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_trim_loader;
  import trim_loader_pkg::*;
  logic        clk_i, rst_n_i, rd, wr, wait_o, pin_oe_o, burn_o;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata_o, lfsr;
  logic        m_norm, m_load, m_commit, line, half_o, slope_o;
  logic [30:0] fuse_state, fuse_word_o;
  logic [9:0]  offs_o, fine_o;
  logic [2:0]  coarse_o;
  logic [4:0]  therm_o;
  logic [36:0] w;
  logic [31:0] exp_q[$];
  int          num_errors, n_checks, cnt, burn_run, burn_last;

  single_wire_trim_loader single_wire_trim_loader_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata_o),
    .avs_waitrequest_o(wait_o), .mode_normal_i(m_norm),
    .mode_load_i(m_load), .mode_commit_i(m_commit), .pin_line_i(line),
    .pin_oe_o(pin_oe_o), .fuse_state_i(fuse_state), .fuse_burn_o(burn_o),
    .fuse_word_o(fuse_word_o), .quiescent_offset_code_o(offs_o),
    .half_supply_range_o(half_o), .coarse_gain_code_o(coarse_o),
    .fine_gain_code_o(fine_o), .slope_reverse_o(slope_o),
    .thermal_comp_code_o(therm_o));

  trim_programmer trim_programmer_i (
    .clk_i(clk_i), .mode_normal_o(m_norm), .mode_load_o(m_load),
    .mode_commit_o(m_commit), .line_o(line));

  // Free-running 25 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Fuse array: zapped cells stay set, and the burn pulse length is timed.
  always @(posedge clk_i) begin
    if (burn_o === 1'b1) begin
      fuse_state <= fuse_state | fuse_word_o;
      burn_run <= burn_run + 1;
    end else if (burn_run != 0) begin
      burn_last <= burn_run;
      burn_run <= 0;
    end
  end

  // Compares one value and counts the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A wait that runs out of its bound counts as a mismatch.
  task automatic give_up();
    num_errors++;
    $display("BAD t=%0t wait ran out", $time);
    close_out();
  endtask

  // Read results are compared against the oldest expected note.
  always @(posedge clk_i) begin
    if (rd === 1'b1 && wait_o === 1'b0) begin
      if (exp_q.size() == 0) begin
        give_up();
      end else begin
        check(rdata_o, exp_q.pop_front());
      end
    end
  end

  // One Avalon transfer; for a read, d is the expected data.
  task automatic bus(input logic w_n, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] e);
    lfsr = lfsr_next(lfsr);
    @(posedge clk_i);
    addr <= a;
    // Write bits and byte lanes that the slave ignores carry random values.
    wdata <= w_n ? {lfsr[31:4], d[3:0]} : d;
    be <= {lfsr[3:1], e[0]};
    wr <= w_n;
    rd <= ~w_n;
    if (!w_n) begin
      exp_q.push_back(d);
    end
    cnt = 0;
    do begin
      @(posedge clk_i);
      cnt++;
    end while (wait_o !== 1'b0 && cnt < 20);
    rd <= 1'b0;
    wr <= 1'b0;
    if (cnt >= 20) begin
      give_up();
    end
  endtask

  // Compares all setting outputs against one image.
  task automatic fields(input logic [29:0] v);
    check({2'h0, therm_o, slope_o, fine_o, coarse_o, half_o, offs_o},
          {2'h0, v});
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Guards the whole run against a hang.
  initial begin
    repeat (100000) @(posedge clk_i);
    give_up();
  end

  // Main sequence.
  initial begin
    {rst_n_i, rd, wr, addr, wdata, be} = '0;
    {fuse_state, burn_run, burn_last, num_errors, n_checks} = '0;
    lfsr = 32'hf;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h1, 4'hf);
    bus(1'b1, 4'h1, 32'hff, 4'hf);
    bus(1'b0, {lfsr[3:2], 2'h1}, 32'h0, 4'hf);
    check(32'(pin_oe_o), 32'h1);
    trim_programmer_i.send('1, 37);
    repeat (2) @(posedge clk_i);
    fields(30'h0);
    $display("test normal band done");
    trim_programmer_i.set_mode(3'b010);
    check(32'(pin_oe_o), 32'h0);
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      w = (k == 1) ? '1 : {lfsr[4:0], lfsr};
      trim_programmer_i.send(w, 37);
      repeat (2) @(posedge clk_i);
      fields(w[29:0]);
      bus(1'b0, REG_SETTINGS, {2'h0, w[29:0]}, 4'hf);
    end
    bus(1'b0, REG_STATUS, 32'ha, 4'hf);
    bus(1'b1, REG_STATUS, 32'h8, 4'h1);
    bus(1'b0, REG_STATUS, 32'h2, 4'hf);
    trim_programmer_i.send('1, 10);
    bus(1'b0, REG_STATUS, 32'h0a02, 4'hf);
    trim_programmer_i.set_mode(3'b100);
    trim_programmer_i.set_mode(3'b010);
    lfsr = lfsr_next(lfsr);
    w = {lfsr[4:0], lfsr};
    trim_programmer_i.send(w, 37);
    repeat (2) @(posedge clk_i);
    fields(w[29:0]);
    bus(1'b1, REG_CTRL, 32'h0, 4'h0);
    bus(1'b1, REG_CTRL, 32'h2, 4'h1);
    trim_programmer_i.send(~w, 37);
    repeat (2) @(posedge clk_i);
    fields(w[29:0]);
    bus(1'b1, REG_CTRL, 32'h3, 4'h1);
    bus(1'b0, REG_CTRL, 32'h3, 4'hf);
    $display("test load mode done");
    trim_programmer_i.set_mode(3'b001);
    cnt = 0;
    while ((burn_last == 0 || burn_o !== 1'b0) && cnt < 3000) begin
      @(posedge clk_i);
      cnt++;
    end
    if (cnt >= 3000) begin
      give_up();
    end
    check(32'(burn_last), 32'(BURN_CYC));
    check({1'b0, fuse_state}, {2'h1, w[29:0]});
    trim_programmer_i.set_mode(3'b100);
    bus(1'b0, REG_STATUS, 32'h29, 4'hf);
    bus(1'b0, REG_SETTINGS, {2'h1, w[29:0]}, 4'hf);
    trim_programmer_i.set_mode(3'b001);
    repeat (20) @(posedge clk_i);
    check(32'(burn_run + burn_o), 32'h0);
    trim_programmer_i.set_mode(3'b100);
    $display("test commit done");
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    fields(w[29:0]);
    bus(1'b0, REG_FUSE, {2'h1, w[29:0]}, 4'hf);
    // A lock fuse seen at power-up refuses any further commit.
    trim_programmer_i.set_mode(3'b001);
    repeat (20) @(posedge clk_i);
    check(32'(burn_run + burn_o), 32'h0);
    trim_programmer_i.set_mode(3'b100);
    $display("test power up from fuses done");
    close_out();
  end
endmodule
`default_nettype wire
